// *** hw/tpft_defines.vh ***
`ifndef TPFT_DEFINES_VH
`define TPFT_DEFINES_VH

// ----------------------------------------
// main register space offsets
// ----------------------------------------
`define TPFT_PORT_SEL_ADDR 8'h1e
`define TPFT_INDEX_ADDR 8'h66
`define TPFT_DATA_ADDR 8'h67

// ----------------------------------------
// port select fields and reset value
// ----------------------------------------
`define TPFT_PORT0_SEL_BIT 0
`define TPFT_PORT1_SEL_BIT 1
`define TPFT_PORT_SEL_RST 8'h01

// ----------------------------------------
// indirect geometry offsets
// ----------------------------------------
`define TPFT_TOTAL_HWIDTH_LOW 8'h04
`define TPFT_TOTAL_VWIDTH_LOW_HWIDTH_HIGH 8'h05
`define TPFT_TOTAL_VWIDTH_HIGH 8'h06
`define TPFT_ACTIVE_HWIDTH_LOW 8'h07
`define TPFT_ACTIVE_VWIDTH_LOW_HWIDTH_HIGH 8'h08
`define TPFT_ACTIVE_VWIDTH_HIGH 8'h09
`define TPFT_HSYNC_PULSE_WIDTH 8'h0a

// ----------------------------------------
// indirect geometry reset values
// ----------------------------------------
`define TPFT_TOTAL_HWIDTH_LOW_RST 8'h48
`define TPFT_TOTAL_VWIDTH_LOW_HWIDTH_HIGH_RST 8'h53
`define TPFT_TOTAL_VWIDTH_HIGH_RST 8'h1e
`define TPFT_ACTIVE_HWIDTH_LOW_RST 8'h20
`define TPFT_ACTIVE_VWIDTH_LOW_HWIDTH_HIGH_RST 8'h03
`define TPFT_ACTIVE_VWIDTH_HIGH_RST 8'h1e
`define TPFT_HSYNC_PULSE_WIDTH_RST 8'h0a

// ----------------------------------------
// nibble field positions in split bytes
// ----------------------------------------
`define TPFT_HIGH_NIB_MSB 3
`define TPFT_HIGH_NIB_LSB 0
`define TPFT_LOW_NIB_MSB 7
`define TPFT_LOW_NIB_LSB 4

`endif

// *** hw/tpft_frame_timing.v ***
`timescale 1ns/10ps
`include "tpft_defines.vh"

module tpft_frame_timing
#(
  parameter NUM_PORTS = 2,
  parameter DIM_WIDTH = 12
)
(
  input wire sys_clk,
  input wire arst_n,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire [NUM_PORTS-1:0] gen_enable,
  output wire [NUM_PORTS-1:0] hsync_out,
  output wire [NUM_PORTS-1:0] active_out,
  output wire [NUM_PORTS-1:0] frame_start
);

  // ----------------------------------------
  // constants and storage
  // ----------------------------------------
  localparam GEO_BYTES = 7; // geometry bytes per port
  localparam [7:0] GEO_BASE = `TPFT_TOTAL_HWIDTH_LOW; // first geometry offset

  reg [7:0] port_sel_reg; // output port select
  reg [7:0] indirect_index_reg; // indirect offset
  reg [7:0] geo_mem [0:NUM_PORTS*GEO_BYTES-1]; // geometry bytes of every port
  reg [7:0] rd_port_byte; // read mux result
  reg [7:0] rd_next; // next read data
  integer i; // reset loop index
  integer p; // write loop index
  integer q; // read loop index, kept apart so each loop variable has one driver
  integer rd_port; // port that answers reads

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // reset value of geometry byte k
  function [7:0] geo_reset;
    input integer k;
    begin
      case (k)
        0: geo_reset = `TPFT_TOTAL_HWIDTH_LOW_RST;
        1: geo_reset = `TPFT_TOTAL_VWIDTH_LOW_HWIDTH_HIGH_RST;
        2: geo_reset = `TPFT_TOTAL_VWIDTH_HIGH_RST;
        3: geo_reset = `TPFT_ACTIVE_HWIDTH_LOW_RST;
        4: geo_reset = `TPFT_ACTIVE_VWIDTH_LOW_HWIDTH_HIGH_RST;
        5: geo_reset = `TPFT_ACTIVE_VWIDTH_HIGH_RST;
        6: geo_reset = `TPFT_HSYNC_PULSE_WIDTH_RST;
        default: geo_reset = 8'h00;
      endcase
    end
  endfunction

  // true when the index names a geometry byte
  function idx_valid;
    input [7:0] idx;
    begin
      idx_valid = (idx >= `TPFT_TOTAL_HWIDTH_LOW) && (idx <= `TPFT_HSYNC_PULSE_WIDTH);
    end
  endfunction

  // low byte plus high nibble taken from the low half of the next byte
  function [11:0] join_low_byte;
    input [7:0] lo;
    input [7:0] hi;
    begin
      join_low_byte = {hi[`TPFT_HIGH_NIB_MSB:`TPFT_HIGH_NIB_LSB], lo};
    end
  endfunction

  // low nibble from the upper half of one byte plus a whole upper byte
  function [11:0] join_high_byte;
    input [7:0] lo;
    input [7:0] hi;
    begin
      join_high_byte = {hi, lo[`TPFT_LOW_NIB_MSB:`TPFT_LOW_NIB_LSB]};
    end
  endfunction

  // ----------------------------------------
  // main register space and indirect writes
  // ----------------------------------------
  // index then data, per selected port
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      port_sel_reg <= `TPFT_PORT_SEL_RST;
      indirect_index_reg <= 8'h00;
      for (i = 0; i < NUM_PORTS*GEO_BYTES; i = i + 1)
      begin
        geo_mem[i] <= geo_reset(i % GEO_BYTES);
      end
    end
    else if (reg_wr_en)
    begin
      case (reg_addr)
        `TPFT_PORT_SEL_ADDR:
        begin
          port_sel_reg <= reg_wdata;
        end
        `TPFT_INDEX_ADDR:
        begin
          indirect_index_reg <= reg_wdata;
        end
        `TPFT_DATA_ADDR:
        begin
          // every selected port takes the byte; unknown offsets drop it
          if (idx_valid(indirect_index_reg))
          begin
            for (p = 0; p < NUM_PORTS; p = p + 1)
            begin
              if (port_sel_reg[p])
              begin
                geo_mem[p*GEO_BYTES + (indirect_index_reg - GEO_BASE)] <= reg_wdata;
              end
            end
          end
        end
        default:
        begin
          // other main-space offsets belong to other blocks
        end
      endcase
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // lowest selected port answers indirect reads
  always @*
  begin
    rd_port = 0;
    rd_port_byte = 8'h00;
    rd_next = reg_rdata;
    for (q = NUM_PORTS-1; q >= 0; q = q - 1)
    begin
      if (port_sel_reg[q])
      begin
        rd_port = q;
      end
    end
    if (idx_valid(indirect_index_reg))
    begin
      rd_port_byte = geo_mem[rd_port*GEO_BYTES + (indirect_index_reg - GEO_BASE)];
    end
    if (reg_rd_en)
    begin
      case (reg_addr)
        `TPFT_PORT_SEL_ADDR: rd_next = port_sel_reg;
        `TPFT_INDEX_ADDR: rd_next = indirect_index_reg;
        `TPFT_DATA_ADDR: rd_next = rd_port_byte;
        default: rd_next = 8'h00;
      endcase
    end
  end

  // read data registered, valid the cycle after the read strobe
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata <= 8'h00;
    end
    else
    begin
      reg_rdata <= rd_next;
    end
  end

  // ----------------------------------------
  // per-port geometry and generators
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g = g + 1)
    begin : port_gen
      wire [11:0] total_line_pixels; // pixels per line
      wire [11:0] total_frame_lines; // lines per frame
      wire [11:0] active_line_pixels; // active pixels per line
      wire [11:0] active_frame_lines; // active lines per frame
      wire [7:0] hsync_pulse_pixels; // hsync width in pixels

      // software keeps these still while gen_enable is high
      assign total_line_pixels = join_low_byte(geo_mem[g*GEO_BYTES], geo_mem[g*GEO_BYTES+1]);
      assign total_frame_lines = join_high_byte(geo_mem[g*GEO_BYTES+1], geo_mem[g*GEO_BYTES+2]);
      assign active_line_pixels = join_low_byte(geo_mem[g*GEO_BYTES+3], geo_mem[g*GEO_BYTES+4]);
      assign active_frame_lines = join_high_byte(geo_mem[g*GEO_BYTES+4], geo_mem[g*GEO_BYTES+5]);
      // zero gives no pulse at all, software avoids it
      assign hsync_pulse_pixels = geo_mem[g*GEO_BYTES+6];

      tpft_line_counter #(
        .WIDTH(DIM_WIDTH)
      ) u_counter (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .gen_enable(gen_enable[g]),
        .total_line_pixels(total_line_pixels),
        .total_frame_lines(total_frame_lines),
        .active_line_pixels(active_line_pixels),
        .active_frame_lines(active_frame_lines),
        .hsync_pulse_pixels(hsync_pulse_pixels),
        .hsync_out(hsync_out[g]),
        .active_out(active_out[g]),
        .frame_start(frame_start[g])
      );
    end
  endgenerate

endmodule // tpft_frame_timing

// *** hw/tpft_line_counter.v ***
`timescale 1ns/10ps
// ----------------------------------------
// pixel and line counters for one port
// ----------------------------------------
module tpft_line_counter
#(
  parameter WIDTH = 12
)
(
  input wire sys_clk,
  input wire arst_n,
  input wire gen_enable,
  input wire [WIDTH-1:0] total_line_pixels,
  input wire [WIDTH-1:0] total_frame_lines,
  input wire [WIDTH-1:0] active_line_pixels,
  input wire [WIDTH-1:0] active_frame_lines,
  input wire [7:0] hsync_pulse_pixels,
  output reg hsync_out,
  output reg active_out,
  output reg frame_start
);

  reg [WIDTH-1:0] pix_cnt_reg; // pixel within line
  reg [WIDTH-1:0] line_cnt_reg; // line within frame
  wire line_end; // last pixel of the line
  wire frame_end; // last line of the frame

  // a total of zero behaves as one so the counters never run away
  assign line_end = ({1'b0, pix_cnt_reg} + {{WIDTH{1'b0}}, 1'b1}) >= {1'b0, total_line_pixels};
  assign frame_end = ({1'b0, line_cnt_reg} + {{WIDTH{1'b0}}, 1'b1}) >= {1'b0, total_frame_lines};

  // ----------------------------------------
  // counters and registered timing outputs
  // ----------------------------------------
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pix_cnt_reg <= {WIDTH{1'b0}};
      line_cnt_reg <= {WIDTH{1'b0}};
      hsync_out <= 1'b0;
      active_out <= 1'b0;
      frame_start <= 1'b0;
    end
    else if (!gen_enable)
    begin
      // disabled: hold at the frame origin, outputs idle
      pix_cnt_reg <= {WIDTH{1'b0}};
      line_cnt_reg <= {WIDTH{1'b0}};
      hsync_out <= 1'b0;
      active_out <= 1'b0;
      frame_start <= 1'b0;
    end
    else
    begin
      // count pixels up to the line total, then lines up to the frame total
      if (line_end)
      begin
        pix_cnt_reg <= {WIDTH{1'b0}};
        line_cnt_reg <= frame_end ? {WIDTH{1'b0}} : line_cnt_reg + 1'b1;
      end
      else
      begin
        pix_cnt_reg <= pix_cnt_reg + 1'b1;
      end
      // sync high for the first hsync_pulse_pixels pixels of every line
      hsync_out <= ({{(WIDTH-8){1'b0}}, hsync_pulse_pixels} > pix_cnt_reg);
      // active at the start of line and frame
      active_out <= (pix_cnt_reg < active_line_pixels) && (line_cnt_reg < active_frame_lines);
      frame_start <= (pix_cnt_reg == {WIDTH{1'b0}}) && (line_cnt_reg == {WIDTH{1'b0}});
    end
  end

endmodule // tpft_line_counter

// *** verif/testbench.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// frame timing testbench
// ----------------------------------------
module testbench;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [1:0] gen_enable = 2'b00;
  wire [7:0] reg_rdata;
  wire [1:0] hsync_out;
  wire [1:0] active_out;
  wire [1:0] frame_start;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] rd_val; // last read result
  logic [7:0] rv [0:6] = '{8'h48, 8'h53, 8'h1e, 8'h20, 8'h03, 8'h1e, 8'h0a}; // reset values
  logic [7:0] ga [0:6] = '{8'h05, 8'h31, 8'h00, 8'h01, 8'h21, 8'h00, 8'h01}; // 261x3, 257x2, sync 1
  logic [7:0] gb [0:6] = '{8'h20, 8'h11, 8'h01, 8'hff, 8'h00, 8'h01, 8'hff}; // 288x17, 255x16, sync 255
  always #20 sys_clk = ~sys_clk;
  tpft_frame_timing #(.NUM_PORTS(2), .DIM_WIDTH(12)) i_dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .gen_enable(gen_enable), .hsync_out(hsync_out), .active_out(active_out),
    .frame_start(frame_start));
  // compare one value
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // compare one register byte
  task chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one register write, strobe for one cycle
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
    @(negedge sys_clk);
  endtask
  // one register read, data one cycle later
  task rd(input logic [7:0] a);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    @(negedge sys_clk);
    rd_val = reg_rdata;
  endtask
  // select ports, then index and data for each geometry byte
  task prog(input logic [7:0] sel, input logic [7:0] g [0:6]);
    wr(8'h1e, sel);
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h66, 8'h04 + i[7:0]);
      wr(8'h67, g[i]);
    end
  endtask
  // read back geometry bytes of the selected port
  task readback(input logic [7:0] sel, input logic [7:0] g [0:6]);
    wr(8'h1e, sel);
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h66, 8'h04 + i[7:0]);
      rd(8'h67);
      chk_byte("geometry byte", g[i], rd_val);
    end
  endtask
  // run one frame and count its cycles, active and sync
  task meas(input int p, input logic [15:0] f, input logic [15:0] a, input logic [15:0] h);
    logic [15:0] nf;
    logic [15:0] na;
    logic [15:0] nh;
    int w;
    nf = 16'h0;
    na = 16'h0;
    nh = 16'h0;
    w = 0;
    gen_enable[p] = 1'b1;
    while (frame_start[p] !== 1'b1 && w < 8)
    begin
      @(negedge sys_clk);
      w++;
    end
    do
    begin
      na += active_out[p];
      nh += hsync_out[p];
      nf++;
      @(negedge sys_clk);
    end while (frame_start[p] !== 1'b1 && nf < 16'd6000);
    gen_enable[p] = 1'b0;
    @(negedge sys_clk);
    chk("frame cycles", f, nf);
    chk("active cycles", a, na);
    chk("sync cycles", h, nh);
  endtask
  // reset values of both ports
  task test_reset;
    readback(8'h01, rv);
    readback(8'h02, rv);
    $display("test_reset done");
  endtask
  // program while disabled, then measure frames on each port
  task test_geom;
    prog(8'h01, ga);
    readback(8'h01, ga);
    readback(8'h02, rv);
    meas(0, 16'd783, 16'd514, 16'd3);
    prog(8'h02, gb);
    readback(8'h02, gb);
    meas(1, 16'd4896, 16'd4080, 16'd4335);
    $display("test_geom done");
  endtask
  // unmapped index and main address read as zero
  task test_unmapped;
    wr(8'h66, 8'h0b);
    wr(8'h67, 8'h55);
    rd(8'h67);
    chk_byte("unmapped index", 8'h00, rd_val);
    rd(8'h10);
    chk_byte("unmapped address", 8'h00, rd_val);
    $display("test_unmapped done");
  endtask
  // write both ports at once, read the main registers, then reset with both generators off
  task test_ports;
    wr(8'h1e, 8'h03);
    wr(8'h66, 8'h0a);
    wr(8'h67, 8'h05);
    wr(8'h1e, 8'h02);
    rd(8'h67);
    chk_byte("both ports port 1", 8'h05, rd_val);
    wr(8'h67, 8'h07);
    rd(8'h67);
    chk_byte("port 1 alone", 8'h07, rd_val);
    wr(8'h1e, 8'h00);
    rd(8'h67);
    chk_byte("no select reads port 0", 8'h05, rd_val);
    rd(8'h1e);
    chk_byte("port select", 8'h00, rd_val);
    rd(8'h66);
    chk_byte("index", 8'h0a, rd_val);
    arst_n = 1'b0;
    @(negedge sys_clk);
    arst_n = 1'b1;
    @(negedge sys_clk);
    rd(8'h1e);
    chk_byte("port select reset", 8'h01, rd_val);
    readback(8'h02, rv);
    $display("test_ports done");
  endtask
  // print counts and verdict
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // cut a hang short
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_mismatch++;
      finish_test;
    end
  end
  initial
  begin
    repeat (12) @(negedge sys_clk);
    arst_n = 1'b1;
    @(negedge sys_clk);
    test_reset;
    test_geom;
    test_unmapped;
    test_ports;
    finish_test;
  end
endmodule // testbench

// *** verif/tpft_checker.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// port checker for frame timing
// ----------------------------------------
module tpft_checker #(parameter NUM_PORTS = 2, parameter DIM_WIDTH = 12)
(
  input wire sys_clk,
  input wire arst_n,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire [NUM_PORTS-1:0] gen_enable,
  input wire [NUM_PORTS-1:0] hsync_out,
  input wire [NUM_PORTS-1:0] active_out,
  input wire [NUM_PORTS-1:0] frame_start
);
  logic [8:0] hs_run; // length of the current port 0 sync pulse
  // count consecutive sync cycles
  always @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
      hs_run <= 9'h0;
    else
      hs_run <= hsync_out[0] ? hs_run + 9'h1 : 9'h0;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_idle_port0: assert property (!gen_enable[0] |=> !hsync_out[0] && !active_out[0] && !frame_start[0])
    else $error("port 0 output while disabled");
  a_idle_port1: assert property (!gen_enable[1] |=> !hsync_out[1] && !active_out[1] && !frame_start[1])
    else $error("port 1 output while disabled");
  a_start_frame: assert property ($rose(gen_enable[0]) |=> frame_start[0])
    else $error("no frame start after enable");
  a_start_sync: assert property (frame_start[0] |-> hsync_out[0])
    else $error("no sync at frame start");
  a_sync_limit: assert property (hs_run <= 9'd255)
    else $error("sync pulse too long");
  a_rdata_hold: assert property (!reg_rd_en |=> $stable(reg_rdata))
    else $error("read data changed without read");
  a_main_unmapped: assert property (reg_rd_en && reg_addr != 8'h1e && reg_addr != 8'h66 && reg_addr != 8'h67
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  cover property (frame_start[0]);
  cover property (frame_start[1]);
  cover property (reg_rd_en && reg_addr == 8'h67);
endmodule // tpft_checker

bind tpft_frame_timing tpft_checker #(.NUM_PORTS(NUM_PORTS), .DIM_WIDTH(DIM_WIDTH)) i_chk (.sys_clk(sys_clk),
  .arst_n(arst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .gen_enable(gen_enable), .hsync_out(hsync_out), .active_out(active_out),
  .frame_start(frame_start));
